/* pll_mode_and_input_select.sv */
// pll mode sequencer, holdover averaging, exit ramp and reference input selection
// assumes loss-of-signal, frequency and lock monitors run on core_clk;
// only the select pins arrive from outside the clock domain
//
// Overview of operation
// - after init enter freerun, outputs on
// - valid selected input starts lock acquisition
// - fast bandwidth during acquisition, then normal
// - locked drives lock loss pin high, flag clear
// - holdover when selected invalid and history exists, freerun if none
// - record frequency history while locked, 120 s
// - holdover frequency averages window after delay
// - valid input during holdover reacquires glitchlessly
// - ramped exit moves linearly to target frequency
// - forty ramp rates, independent of loop bandwidth
// - same ramp rates for exit and switching
// - unramped exit uses loop or exit bandwidth
// - reference select, external clock removes caps
// - manual select by pins or register, pins default
// - manual input without clock: freerun or holdover
// - zero delay makes input three feedback only
// - automatic selects only valid inputs, else holdover or freerun
// - revertive always picks highest priority valid input
// - non-revertive keeps active input while valid
// - hitless switching absorbs fixed phase offset
// - without hitless, offset slews at loop bandwidth
// - loss and frequency monitors qualify each input
`timescale 1ns/1ps
`include "pll_mode_map.svh"

module pll_mode_and_input_select
  import pll_mode_pkg::*;
#(
  parameter int unsigned SAMPLE_CYCLES = `SAMPLE_CYCLES,
  parameter int unsigned RAMP_CYCLES   = `RAMP_CYCLES
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // initialisation and monitors
  input  wire logic              init_done,
  input  wire logic [3:0]        signal_loss_flag,
  input  wire logic [3:0]        frequency_fault_flag,
  input  wire logic              lock_detect,
  input  wire logic [15:0]       loop_freq,
  input  wire logic [15:0]       target_freq,
  // configuration
  input  wire logic              fastlock_en,
  input  wire logic              external_reference_option,
  input  wire logic              zero_delay_option,
  input  wire logic              sel_by_register,
  input  wire logic [1:0]        sel_register,
  input  wire logic [1:0]        sel_pins,
  input  wire logic              auto_select,
  input  wire logic              revertive,
  input  wire logic              hitless_en,
  input  wire logic              ramp_exit_en,
  input  wire logic              ramp_switch_en,
  input  wire logic              exit_bw_en,
  input  wire logic [5:0]        ramp_rate,
  input  wire logic [2:0]        avg_window_log2,
  input  wire logic [6:0]        avg_delay,
  // status and loop control
  output logic [1:0]             mode,
  output logic                   lock_loss_pin_n,
  output logic                   lock_loss_flag,
  output logic                   outputs_en,
  output logic                   xtal_caps_en,
  output logic [1:0]             active_input,
  output logic                   active_valid,
  output logic [1:0]             loop_bw_sel,
  output logic                   freq_override,
  output logic [15:0]            freq_cmd,
  output logic                   phase_absorb,
  output logic                   phase_slew
);

  // ***************************************************************
  // select pin synchroniser
  // ***************************************************************
  logic [1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_sel_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_s1_q  <= 2'h0;
      pin_s2_q  <= 2'h0;
      pin_s3_q  <= 2'h0;
      pin_sel_q <= 2'h0;
    end else begin
      pin_s1_q <= sel_pins;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      if (pin_s2_q == pin_s3_q) begin
        pin_sel_q <= pin_s3_q;
      end
    end
  end

  // ***************************************************************
  // input qualification and selection
  // ***************************************************************
  logic [3:0] valid_m;
  logic [1:0] manual_sel, best_sel, sel_d, sel_q;
  logic       any_valid, sel_valid_d, sel_valid_q, switched;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_qual
      assign valid_m[gi] = !signal_loss_flag[gi] && !frequency_fault_flag[gi] &&
                           !(zero_delay_option && gi == 3);
    end
  endgenerate

  // pins decode straight to the input index; pins win after reset
  assign manual_sel  = sel_by_register ? sel_register : pin_sel_q;
  assign any_valid   = |valid_m;
  // lowest index is highest priority
  assign best_sel    = valid_m[0] ? 2'h0 : valid_m[1] ? 2'h1 :
                       valid_m[2] ? 2'h2 : 2'h3;
  assign sel_d       = !auto_select ? manual_sel :
                       (revertive || !valid_m[sel_q]) ? best_sel : sel_q;
  assign sel_valid_d = auto_select ? any_valid : valid_m[manual_sel];
  assign switched    = sel_valid_q && sel_valid_d && (sel_d != sel_q);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sel_q       <= 2'h0;
      sel_valid_q <= 1'b0;
    end else begin
      sel_q       <= sel_d;
      sel_valid_q <= sel_valid_d;
    end
  end

  // ***************************************************************
  // frequency history while locked
  // ***************************************************************
  logic [15:0]  hist_q [`HIST_DEPTH];
  logic [6:0]   wr_q, fill_q;
  logic [31:0]  smp_cnt_q;
  logic         smp_tick;
  pll_mode_t    state_q, state_d;

  assign smp_tick = (smp_cnt_q == SAMPLE_CYCLES - 1);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      smp_cnt_q <= 32'h0;
      wr_q      <= 7'h0;
      fill_q    <= 7'h0;
    end else if (state_q != MODE_LOCKED) begin
      smp_cnt_q <= 32'h0;
    end else begin
      smp_cnt_q <= smp_tick ? 32'h0 : smp_cnt_q + 32'h1;
      if (smp_tick) begin
        wr_q   <= (wr_q == 7'(`HIST_DEPTH - 1)) ? 7'h0 : wr_q + 7'h1;
        fill_q <= (fill_q == 7'(`HIST_DEPTH)) ? fill_q : fill_q + 7'h1;
      end
    end
  end

  generate
    for (gi = 0; gi < `HIST_DEPTH; gi++) begin : g_hist
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          hist_q[gi] <= 16'h0;
        end else if (state_q == MODE_LOCKED && smp_tick && wr_q == 7'(gi)) begin
          hist_q[gi] <= loop_freq;
        end
      end
    end
  endgenerate

  // ***************************************************************
  // holdover averaging engine
  // ***************************************************************
  logic                avg_busy_q;
  logic [6:0]          rd_q, left_q, start_idx, span;
  logic [`SUM_W-1:0]   sum_q;
  logic [15:0]         hold_freq_q;
  logic                enter_hold;

  assign enter_hold = (state_d == MODE_HOLDOVER) && (state_q != MODE_HOLDOVER);
  // skip the newest samples, which may be corrupt by the failure
  assign start_idx  = (wr_q > avg_delay) ? wr_q - avg_delay - 7'h1
                      : 7'(`HIST_DEPTH - 1) - (avg_delay - wr_q);
  assign span       = 7'h1 << avg_window_log2;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      avg_busy_q  <= 1'b0;
      rd_q        <= 7'h0;
      left_q      <= 7'h0;
      sum_q       <= '0;
      hold_freq_q <= 16'h0;
    end else if (enter_hold) begin
      avg_busy_q <= 1'b1;
      rd_q       <= start_idx;
      left_q     <= span;
      sum_q      <= '0;
    end else if (avg_busy_q) begin
      sum_q  <= sum_q + `SUM_W'(hist_q[rd_q]);
      rd_q   <= (rd_q == 7'h0) ? 7'(`HIST_DEPTH - 1) : rd_q - 7'h1;
      left_q <= left_q - 7'h1;
      if (left_q == 7'h1) begin
        avg_busy_q  <= 1'b0;
        hold_freq_q <= 16'((sum_q + `SUM_W'(hist_q[rd_q])) >> avg_window_log2);
      end
    end
  end

  // ***************************************************************
  // ramp generator for holdover exit and input switching
  // ***************************************************************
  logic        ramp_q, ramp_start, rtick;
  logic [31:0] rcnt_q;
  logic [15:0] rstep, ramp_freq_q, rdiff;
  logic [5:0]  rcode;

  // codes above the last setting clamp to the fastest one
  assign rcode = (ramp_rate >= `RAMP_CODES) ? `RAMP_CODES - 6'h1 : ramp_rate;
  assign rstep = 16'({2'h0, rcode[1:0]} + 4'h1) << rcode[5:2];
  assign rtick = (rcnt_q == RAMP_CYCLES - 1);
  assign rdiff = (ramp_freq_q > target_freq) ? ramp_freq_q - target_freq
                 : target_freq - ramp_freq_q;
  assign ramp_start = ((state_q == MODE_HOLDOVER) && (state_d == MODE_ACQUIRE) && ramp_exit_en)
                      || (switched && ramp_switch_en && state_q != MODE_HOLDOVER);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ramp_q      <= 1'b0;
      rcnt_q      <= 32'h0;
      ramp_freq_q <= 16'h0;
    end else if (ramp_start) begin
      ramp_q      <= 1'b1;
      rcnt_q      <= 32'h0;
      ramp_freq_q <= (state_q == MODE_HOLDOVER) ? hold_freq_q : loop_freq;
    end else if (ramp_q) begin
      rcnt_q <= rtick ? 32'h0 : rcnt_q + 32'h1;
      if (rtick) begin
        if (rdiff <= rstep) begin
          ramp_freq_q <= target_freq;
          ramp_q      <= 1'b0;
        end else if (ramp_freq_q > target_freq) begin
          ramp_freq_q <= ramp_freq_q - rstep;
        end else begin
          ramp_freq_q <= ramp_freq_q + rstep;
        end
      end
    end
  end

  // ***************************************************************
  // mode sequencer
  // ***************************************************************
  logic init_seen_q, from_hold_q;
  logic fall_back;

  assign fall_back = (fill_q != 7'h0);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      MODE_FREERUN: begin
        if (init_seen_q && sel_valid_q) begin
          state_d = MODE_ACQUIRE;
        end
      end
      MODE_ACQUIRE: begin
        if (!sel_valid_q) begin
          state_d = fall_back ? MODE_HOLDOVER : MODE_FREERUN;
        end else if (switched) begin
          state_d = MODE_ACQUIRE;
        end else if (lock_detect && !ramp_q) begin
          state_d = MODE_LOCKED;
        end
      end
      MODE_LOCKED: begin
        if (!sel_valid_q) begin
          state_d = fall_back ? MODE_HOLDOVER : MODE_FREERUN;
        end else if (switched || !lock_detect) begin
          state_d = MODE_ACQUIRE;
        end
      end
      MODE_HOLDOVER: begin
        if (sel_valid_q && !avg_busy_q) begin
          state_d = MODE_ACQUIRE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q     <= MODE_FREERUN;
      init_seen_q <= 1'b0;
      from_hold_q <= 1'b0;
    end else begin
      state_q     <= init_seen_q ? state_d : MODE_FREERUN;
      init_seen_q <= init_seen_q | init_done;
      if (state_q == MODE_HOLDOVER) begin
        from_hold_q <= 1'b1;
      end else if (state_q == MODE_LOCKED) begin
        from_hold_q <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // registered outputs
  // ***************************************************************
  loop_bw_t bw_d;
  logic     is_locked;

  assign is_locked = (state_q == MODE_LOCKED);
  assign bw_d = (state_q != MODE_ACQUIRE) ? BW_NORMAL :
                (from_hold_q && !ramp_exit_en && exit_bw_en) ? BW_EXIT :
                fastlock_en ? BW_FAST : BW_NORMAL;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode            <= 2'h0;
      lock_loss_pin_n <= 1'b0;
      lock_loss_flag  <= 1'b1;
      outputs_en      <= 1'b0;
      xtal_caps_en    <= 1'b1;
      active_input    <= 2'h0;
      active_valid    <= 1'b0;
      loop_bw_sel     <= 2'h0;
      freq_override   <= 1'b0;
      freq_cmd        <= 16'h0;
      phase_absorb    <= 1'b0;
      phase_slew      <= 1'b0;
    end else begin
      mode            <= state_q;
      lock_loss_pin_n <= is_locked;
      lock_loss_flag  <= !is_locked;
      outputs_en      <= init_seen_q;
      xtal_caps_en    <= !external_reference_option;
      active_input    <= sel_q;
      active_valid    <= sel_valid_q;
      loop_bw_sel     <= bw_d;
      freq_override   <= ramp_q || state_q == MODE_HOLDOVER;
      freq_cmd        <= (state_q == MODE_HOLDOVER) ? hold_freq_q : ramp_freq_q;
      phase_absorb    <= switched && hitless_en;
      if (switched) begin
        phase_slew <= !hitless_en;
      end else if (is_locked) begin
        phase_slew <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  property p_lock_pin;
    @(posedge core_clk) disable iff (rst)
    is_locked |=> lock_loss_pin_n && !lock_loss_flag;
  endproperty
  a_lock_pin: assert property (p_lock_pin) else $error("lock pin wrong when locked");

  property p_init_out;
    @(posedge core_clk) disable iff (rst)
    init_done |-> ##2 outputs_en && mode == 2'h0 || mode != 2'h0;
  endproperty
  a_init_out: assert property (p_init_out) else $error("outputs off after init");

  property p_acquire;
    @(posedge core_clk) disable iff (rst)
    init_seen_q && state_q == MODE_FREERUN && sel_valid_q |=> state_q == MODE_ACQUIRE;
  endproperty
  a_acquire: assert property (p_acquire) else $error("no acquisition on valid input");

  property p_holdover;
    @(posedge core_clk) disable iff (rst)
    init_seen_q && is_locked && !sel_valid_q && fill_q != 7'h0 |=> state_q == MODE_HOLDOVER;
  endproperty
  a_holdover: assert property (p_holdover) else $error("holdover not entered");

  property p_feedback;
    @(posedge core_clk) disable iff (rst)
    zero_delay_option && $past(zero_delay_option) |-> !(sel_valid_q && sel_q == `FEEDBACK_INPUT);
  endproperty
  a_feedback: assert property (p_feedback) else $error("feedback input selected");

  property p_revert;
    @(posedge core_clk) disable iff (rst)
    auto_select && revertive && valid_m[0] |=> sel_q == 2'h0;
  endproperty
  a_revert: assert property (p_revert) else $error("revertive missed input zero");

  property p_keep;
    @(posedge core_clk) disable iff (rst)
    auto_select && !revertive && valid_m[sel_q] |=> $stable(sel_q);
  endproperty
  a_keep: assert property (p_keep) else $error("non-revertive left valid input");

  property p_caps;
    @(posedge core_clk) disable iff (rst)
    external_reference_option ##1 external_reference_option |-> !xtal_caps_en;
  endproperty
  a_caps: assert property (p_caps) else $error("crystal caps on with external clock");

  property p_fast;
    @(posedge core_clk) disable iff (rst)
    state_q == MODE_ACQUIRE && fastlock_en && !from_hold_q |=> loop_bw_sel == BW_FAST;
  endproperty
  a_fast: assert property (p_fast) else $error("fast bandwidth not used");

endmodule // pll_mode_and_input_select

/* pll_mode_and_input_select_tb_top.sv */
// self-checking bench for the pll mode and input selection block
// assumes the reference model file and the design package are compiled first
`timescale 1ns/1ps

module pll_mode_and_input_select_tb_top;
  import pll_mode_pkg::*;
  logic        core_clk, rst, init_done, lock_detect, fastlock_en, external_reference_option;
  logic        zero_delay_option, sel_by_register, auto_select, revertive, hitless_en;
  logic        ramp_exit_en, ramp_switch_en, exit_bw_en, lock_loss_pin_n, lock_loss_flag;
  logic        outputs_en, xtal_caps_en, active_valid, freq_override, phase_absorb, phase_slew;
  int          absorb_cnt, slew_cnt, cnt_base;
  logic [3:0]  signal_loss_flag, frequency_fault_flag, in_dead, in_offfreq;
  logic [15:0] loop_freq, target_freq, freq_cmd;
  logic [1:0]  sel_register, sel_pins, mode, active_input, loop_bw_sel;
  logic [5:0]  ramp_rate;
  logic [2:0]  avg_window_log2;
  logic [6:0]  avg_delay;
  logic [7:0]  lock_delay;
  int          errors, check_count;

  pll_mode_and_input_select #(.SAMPLE_CYCLES(16), .RAMP_CYCLES(4)) dut (
    .core_clk(core_clk), .rst(rst), .init_done(init_done), .signal_loss_flag(signal_loss_flag),
    .frequency_fault_flag(frequency_fault_flag), .lock_detect(lock_detect), .loop_freq(loop_freq),
    .target_freq(target_freq), .fastlock_en(fastlock_en), .external_reference_option(external_reference_option),
    .zero_delay_option(zero_delay_option), .sel_by_register(sel_by_register), .sel_register(sel_register),
    .sel_pins(sel_pins), .auto_select(auto_select), .revertive(revertive), .hitless_en(hitless_en),
    .ramp_exit_en(ramp_exit_en), .ramp_switch_en(ramp_switch_en), .exit_bw_en(exit_bw_en),
    .ramp_rate(ramp_rate), .avg_window_log2(avg_window_log2), .avg_delay(avg_delay), .mode(mode),
    .lock_loss_pin_n(lock_loss_pin_n), .lock_loss_flag(lock_loss_flag), .outputs_en(outputs_en),
    .xtal_caps_en(xtal_caps_en), .active_input(active_input), .active_valid(active_valid),
    .loop_bw_sel(loop_bw_sel), .freq_override(freq_override), .freq_cmd(freq_cmd),
    .phase_absorb(phase_absorb), .phase_slew(phase_slew));

  ref_source_model partner (
    .core_clk(core_clk), .rst(rst), .in_dead(in_dead), .in_offfreq(in_offfreq), .lock_delay(lock_delay),
    .mode(mode), .signal_loss_flag(signal_loss_flag), .frequency_fault_flag(frequency_fault_flag),
    .lock_detect(lock_detect));

  // ****************************************
  // clock, pulse catchers and shared tasks
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // switch pulses are counted between the edges that launch them
  always @(negedge core_clk or posedge rst) begin
    if (rst) begin
      absorb_cnt <= 0;
      slew_cnt   <= 0;
    end else begin
      if (phase_absorb === 1'b1) absorb_cnt <= absorb_cnt + 1;
      if (phase_slew === 1'b1) slew_cnt <= slew_cnt + 1;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic wait_mode(input logic [1:0] m, input int limit);
    int i;
    i = 0;
    while (mode !== m && i < limit) begin
      @(negedge core_clk);
      i++;
    end
    chk({14'h0, mode}, {14'h0, m}, "mode");
  endtask

  task automatic wait_freq(input logic [15:0] f, input int limit);
    int i;
    i = 0;
    while (freq_cmd !== f && i < limit) begin
      @(negedge core_clk);
      i++;
    end
    chk(freq_cmd, f, "freq_cmd");
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #(25 * 6000);
    errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    end_of_test();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst = 1'b1; init_done = 1'b0; in_dead = 4'hf; in_offfreq = 4'h0; lock_delay = 8'hff;
    loop_freq = 16'h1234; target_freq = 16'h1240; fastlock_en = 1'b1; external_reference_option = 1'b0;
    zero_delay_option = 1'b0; sel_by_register = 1'b0; sel_register = 2'h0; sel_pins = 2'h0;
    auto_select = 1'b0; revertive = 1'b1; hitless_en = 1'b1; ramp_exit_en = 1'b0; ramp_switch_en = 1'b0;
    exit_bw_en = 1'b0; ramp_rate = 6'h00; avg_window_log2 = 3'h2; avg_delay = 7'h00;
    errors = 0; check_count = 0;
    repeat (20) @(negedge core_clk);
    rst = 1'b0;
    chk({15'h0, lock_loss_flag}, 16'h1, "flag after reset");
    chk({15'h0, xtal_caps_en}, 16'h1, "caps after reset");
    cyc(2);
    init_done = 1'b1;
    wait_mode(MODE_FREERUN, 4);
    cyc(3);
    chk({15'h0, outputs_en}, 16'h1, "outputs on");
    external_reference_option = 1'b1;
    cyc(2);
    chk({15'h0, xtal_caps_en}, 16'h0, "caps out");
    external_reference_option = 1'b0;
    cyc(2);
    chk({15'h0, xtal_caps_en}, 16'h1, "caps in");
    in_dead = 4'h0;
    for (int i = 3; i >= 0; i--) begin
      sel_pins = 2'(i);
      cyc(8);
      chk({14'h0, active_input}, 16'(i), "pin select");
    end
    sel_by_register = 1'b1;
    sel_pins = 2'h3;
    for (int i = 0; i < 4; i++) begin
      sel_register = 2'(3 - i);
      cyc(8);
      chk({14'h0, active_input}, 16'(3 - i), "register select");
    end
    wait_mode(MODE_ACQUIRE, 4);
    chk({14'h0, loop_bw_sel}, {14'h0, BW_FAST}, "fast bw");
    chk({15'h0, lock_loss_pin_n}, 16'h0, "pin unlocked");
    lock_delay = 8'd10;
    wait_mode(MODE_LOCKED, 20);
    cyc(2);
    chk({15'h0, lock_loss_pin_n}, 16'h1, "pin locked");
    chk({15'h0, lock_loss_flag}, 16'h0, "flag locked");
    chk({14'h0, loop_bw_sel}, {14'h0, BW_NORMAL}, "normal bw");
    cyc(200);
    auto_select = 1'b1;
    sel_by_register = 1'b0;
    cyc(6);
    chk({14'h0, active_input}, 16'h0, "auto best");
    cnt_base = absorb_cnt;
    in_dead = 4'h1;
    cyc(6);
    chk({14'h0, active_input}, 16'h1, "auto fallback");
    chk({15'h0, absorb_cnt == cnt_base + 1}, 16'h1, "absorb pulse");
    in_dead = 4'h0;
    cyc(6);
    chk({14'h0, active_input}, 16'h0, "revert");
    revertive = 1'b0;
    hitless_en = 1'b0;
    cnt_base = slew_cnt;
    in_offfreq = 4'h1;
    cyc(6);
    chk({14'h0, active_input}, 16'h1, "offfreq leaves");
    chk({15'h0, slew_cnt > cnt_base}, 16'h1, "slew level");
    in_offfreq = 4'h0;
    cyc(6);
    chk({14'h0, active_input}, 16'h1, "no revert");
    wait_mode(MODE_LOCKED, 60);
    cyc(200);
    in_dead = 4'hf;
    wait_mode(MODE_HOLDOVER, 10);
    wait_freq(16'h1234, 30);
    chk({15'h0, freq_override}, 16'h1, "override");
    zero_delay_option = 1'b1;
    in_dead = 4'h7;
    cyc(10);
    chk({14'h0, mode}, {14'h0, MODE_HOLDOVER}, "auto feedback");
    auto_select = 1'b0;
    sel_pins = 2'h3;
    cyc(8);
    chk({15'h0, active_valid}, 16'h0, "pin feedback");
    ramp_exit_en = 1'b1;
    zero_delay_option = 1'b0;
    wait_freq(16'h1240, 200);
    wait_mode(MODE_LOCKED, 60);
    cyc(40);
    in_dead = 4'h8;
    wait_mode(MODE_HOLDOVER, 10);
    ramp_exit_en = 1'b0;
    exit_bw_en = 1'b1;
    fastlock_en = 1'b0;
    in_dead = 4'h0;
    wait_mode(MODE_ACQUIRE, 30);
    chk({14'h0, loop_bw_sel}, {14'h0, BW_EXIT}, "exit bw");
    cyc(20);
    ramp_switch_en = 1'b1;
    ramp_rate = 6'h3f;
    target_freq = 16'h3234;
    sel_pins = 2'h2;
    wait_freq(16'h1a34, 20);
    chk({15'h0, freq_override}, 16'h1, "switch ramp override");
    wait_freq(16'h3234, 30);
    end_of_test();
  end
endmodule // pll_mode_and_input_select_tb_top

/* pll_mode_map.svh */
// constants for the pll mode and input selection block
// assumes a 40 MHz core clock; included by bare name
`ifndef PLL_MODE_MAP_SVH
`define PLL_MODE_MAP_SVH

`define CORE_CLK_KHZ     40000
`define HIST_DEPTH       120
`define HIST_IDX_W       7
`define SAMPLE_TIME_MS   1000
`define SAMPLE_CYCLES    (`SAMPLE_TIME_MS * `CORE_CLK_KHZ)
`define RAMP_TICK_US     1000
`define RAMP_CYCLES      ((`RAMP_TICK_US * `CORE_CLK_KHZ) / 1000)
`define RAMP_CODES       6'h28
`define FREQ_W           16
`define SUM_W            23
`define FEEDBACK_INPUT   2'h3
`define PIN_SEL_RESET    1'b0

`endif

/* pll_mode_pkg.sv */
// types for the pll mode and input selection block
// assumes nothing beyond the constant header
package pll_mode_pkg;

  typedef enum logic [1:0] {
    MODE_FREERUN  = 2'b00,
    MODE_ACQUIRE  = 2'b01,
    MODE_LOCKED   = 2'b10,
    MODE_HOLDOVER = 2'b11
  } pll_mode_t;

  typedef enum logic [1:0] {
    BW_NORMAL = 2'b00,
    BW_FAST   = 2'b01,
    BW_EXIT   = 2'b10
  } loop_bw_t;

endpackage

/* ref_source_model.sv */
// model of the reference inputs and their monitors facing the mode block
// assumes the block's mode output and scenario controls from the testbench
`timescale 1ns/1ps

module ref_source_model
  import pll_mode_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // scenario controls
  input  wire logic [3:0] in_dead,
  input  wire logic [3:0] in_offfreq,
  input  wire logic [7:0] lock_delay,
  input  wire logic [1:0] mode,
  // monitor results
  output logic [3:0]      signal_loss_flag,
  output logic [3:0]      frequency_fault_flag,
  output logic            lock_detect
);
  // ****************************************
  // monitors and loop lock detector
  // ****************************************
  logic [7:0] lock_cnt_q;
  wire        in_loop = (mode == MODE_ACQUIRE) || (mode == MODE_LOCKED);

  // a large lock_delay gives a slow lock, a small one a prompt lock
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      signal_loss_flag     <= 4'hf;
      frequency_fault_flag <= 4'h0;
      lock_cnt_q           <= 8'h00;
      lock_detect          <= 1'b0;
    end else begin
      signal_loss_flag     <= in_dead;
      frequency_fault_flag <= in_offfreq;
      if (!in_loop)
        lock_cnt_q <= 8'h00;
      else if (lock_cnt_q != 8'hff)
        lock_cnt_q <= lock_cnt_q + 8'h01;
      lock_detect <= in_loop && (lock_cnt_q >= lock_delay);
    end
  end
endmodule // ref_source_model
